// File: src/tbcc_top.sv
`timescale 1ns/1ps
module tbcc_top #(
  parameter int COPY_ROWS = tbcc_pkg::OTP_ROWS - 1
) (
  input  wire logic                          clk,                // 100 MHz clock
  input  wire logic                          rst,                // Sync reset
  input  wire logic [1:0]                    pll_strap,          // Clock strap pins
  input  wire logic [2:0]                    boot_strap,         // Boot strap pins
  input  wire logic [tbcc_pkg::OSC_W-1:0]    osc_khz,            // Oscillator rate
  input  wire logic                          cfg_wr,             // Clock config write
  input  wire logic [tbcc_pkg::OD_W-1:0]     cfg_output_divider, // New output divider
  input  wire logic [tbcc_pkg::FB_W-1:0]     cfg_fb_mult,        // New multiplier
  input  wire logic [tbcc_pkg::IN_W-1:0]     cfg_in_div,         // New input divider
  output logic [tbcc_pkg::OD_W-1:0]          output_divider,     // Active output divider
  output logic [tbcc_pkg::FB_W-1:0]          fb_mult,            // Active multiplier
  output logic [tbcc_pkg::IN_W-1:0]          in_div,             // Active input divider
  output logic [31:0]                        tile_khz,           // Tile clock rate
  output logic                               vco_range_err,      // VCO out of band
  output logic [tbcc_pkg::TIMER_W-1:0]       timer_value,        // Reference timer
  output logic                               otp_rd_req,         // OTP read request
  output logic [tbcc_pkg::OTP_AW-1:0]        otp_rd_addr,        // OTP row
  input  wire logic [31:0]                   otp_rd_data,        // OTP row data
  input  wire logic                          otp_rd_valid,       // OTP data valid
  input  wire logic                          sw_otp_req,         // Software OTP access
  input  wire logic [tbcc_pkg::OTP_AW-1:0]   sw_otp_addr,        // Software OTP row
  output logic                               sw_otp_grant,       // Access allowed
  output logic                               sw_otp_refused,     // Access locked
  output logic [31:0]                        security_word,      // Loaded security word
  output tbcc_pkg::tbcc_src_e                first_tile_src,     // Boot source
  output tbcc_pkg::tbcc_src_e                second_tile_src,    // Boot source
  output logic                               link_b_en,          // Link B enabled
  output logic                               internal_links_en,  // Links E-H enabled
  output logic                               boot_rom_bypass,    // Start from OTP
  output logic [tbcc_pkg::OTP_AW-1:0]        boot_otp_addr,      // OTP start row
  output logic                               boot_go,            // Boot start pulse
  input  wire logic                          cpu_mem_en,         // Processor access
  input  wire logic                          cpu_mem_we,         // Processor write
  input  wire tbcc_pkg::tbcc_size_e          cpu_mem_size,       // Access width
  input  wire logic [tbcc_pkg::SRAM_AW-1:0]  cpu_mem_addr,       // Byte address
  input  wire logic [31:0]                   cpu_mem_wdata,      // Write data
  output logic [31:0]                        cpu_mem_rdata,      // Read data
  output logic                               cpu_mem_ready,      // SRAM free
  input  wire logic                          dbg_req,            // Scan port access
  output logic                               dbg_grant,          // Scan access allowed
  input  wire logic                          link_acc_req,       // Remote tile access
  output logic                               link_acc_grant,     // Remote access allowed
  input  wire logic                          debug_sync_in_n,    // Sync pin level
  output logic                               debug_sync_out,     // Sync pin drive
  output logic                               debug_sync_oe,      // Sync pin enable
  input  wire logic                          debug_break,        // Breakpoint hit
  output logic                               debug_sync_event    // Sync request seen
);
  import tbcc_pkg::*;

  logic [1:0] pll_meta_reg, pll_sync_reg;
  logic [2:0] boot_meta_reg, boot_sync_reg;
  logic       dsync_meta_reg, dsync_sync_reg;
  logic [1:0] edge_cnt_reg, edge_cnt_next;
  logic       strap_done_reg, strap_done_next;
  logic [1:0] pll_code_reg, pll_code_next;
  logic [2:0] boot_mode_reg, boot_mode_next;
  tbcc_pll_s  pll_reg, pll_next;
  logic [7:0] pre_reg, pre_next;
  logic [TIMER_W-1:0] timer_reg, timer_next;
  logic       tick;
  logic [31:0] tile_khz_reg, tile_khz_next;
  logic       range_err_reg, range_err_next;
  logic [47:0] vco_khz;
  tbcc_ld_e   ld_reg, ld_next;
  logic [OTP_AW-1:0] row_reg, row_next;
  logic [31:0] sec_reg, sec_next;
  logic       go_reg, go_next;
  tbcc_src_e  src0_reg, src0_next, src1_reg, src1_next;
  logic       links_reg, links_next;
  logic       bypass_reg, bypass_next;
  logic       sec_valid, copy_wr, run, secure;
  logic       sector_lock;
  tbcc_mem_if mem ();

  // Two flops on every pin before use
  always_ff @(posedge clk) begin
    if (rst) begin
      pll_meta_reg   <= 2'h0;
      pll_sync_reg   <= 2'h0;
      boot_meta_reg  <= 3'h0;
      boot_sync_reg  <= 3'h0;
      dsync_meta_reg <= 1'h1;
      dsync_sync_reg <= 1'h1;
    end else begin
      pll_meta_reg   <= pll_strap;
      pll_sync_reg   <= pll_meta_reg;
      boot_meta_reg  <= boot_strap;
      boot_sync_reg  <= boot_meta_reg;
      dsync_meta_reg <= debug_sync_in_n;
      dsync_sync_reg <= dsync_meta_reg;
    end
  end

  // Straps captured on the third edge after reset; pins stay static until then
  always_comb begin
    edge_cnt_next   = edge_cnt_reg;
    strap_done_next = strap_done_reg;
    pll_code_next   = pll_code_reg;
    boot_mode_next  = boot_mode_reg;
    if (!strap_done_reg) begin
      edge_cnt_next = edge_cnt_reg + 2'h1;
      if (edge_cnt_reg == 2'(STRAP_EDGE - 1)) begin
        strap_done_next = 1'b1;
        pll_code_next   = pll_sync_reg;
        boot_mode_next  = boot_sync_reg;
      end
    end
  end

  // Clock setting: strap default first, then software rewrites
  always_comb begin
    pll_next = pll_reg;
    if (!strap_done_reg && edge_cnt_reg == 2'(STRAP_EDGE - 1)) begin
      pll_next = tbcc_pll_default(pll_sync_reg);
    end else if (cfg_wr && strap_done_reg) begin
      pll_next = '{od: cfg_output_divider, fb: cfg_fb_mult, r: cfg_in_div};
    end
  end

  // Field widths bound the ranges; the VCO band is only flagged
  always_comb begin
    vco_khz = (48'(osc_khz) * (48'(pll_reg.fb) + 48'h1))
              / (48'(FB_HALF) * (48'(pll_reg.r) + 48'h1));
    tile_khz_next = 32'(vco_khz / (48'(pll_reg.od) + 48'h1));
    range_err_next = vco_khz < 48'(VCO_MIN_KHZ) || vco_khz > 48'(VCO_MAX_KHZ);
  end

  // Reference timer, one count per 10 ns tick
  always_comb begin
    tick       = pre_reg == 8'(TICK_CYC - 1);
    pre_next   = tick ? 8'h00 : pre_reg + 8'h01;
    timer_next = tick ? timer_reg + 32'h1 : timer_reg;
  end

  // Loader: security word, then row copy, then boot
  always_comb begin
    ld_next    = ld_reg;
    row_next   = row_reg;
    sec_next   = sec_reg;
    go_next    = 1'b0;
    src0_next  = src0_reg;
    src1_next  = src1_reg;
    links_next = links_reg;
    bypass_next = bypass_reg;
    unique case (ld_reg)
      LD_STRAP: if (strap_done_reg) ld_next = LD_SEC;
      LD_SEC: if (otp_rd_valid) begin
        sec_next = otp_rd_data;
        row_next = OTP_AW'(1);
        ld_next  = (COPY_ROWS == 0) ? LD_BOOT : LD_COPY;
      end
      LD_COPY: if (otp_rd_valid) begin
        row_next = row_reg + OTP_AW'(1);
        if (row_reg == OTP_AW'(COPY_ROWS)) ld_next = LD_BOOT;
      end
      LD_BOOT: begin
        go_next = 1'b1;
        ld_next = LD_RUN;
        if (secure) begin
          src0_next   = SRC_OTP;
          src1_next   = SRC_OTP;
          bypass_next = 1'b1;
          links_next  = 1'b0;
        end else begin
          src0_next   = tbcc_boot_src(boot_mode_reg, 1'b0);
          src1_next   = tbcc_boot_src(boot_mode_reg, 1'b1);
          bypass_next = 1'b0;
          links_next  = boot_mode_reg == BOOT_CHAN;
        end
      end
      LD_RUN: ld_next = LD_RUN;
      default: ld_next = LD_STRAP;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      edge_cnt_reg   <= 2'h0;
      strap_done_reg <= 1'b0;
      pll_code_reg   <= 2'h0;
      boot_mode_reg  <= 3'h0;
      pll_reg        <= PLL_DEF_00;
      pre_reg        <= 8'h00;
      timer_reg      <= 32'h0;
      tile_khz_reg   <= 32'h0;
      range_err_reg  <= 1'b0;
      ld_reg         <= LD_STRAP;
      row_reg        <= 11'h000;
      sec_reg        <= 32'h0;
      go_reg         <= 1'b0;
      src0_reg       <= SRC_DEBUG_WAIT;
      src1_reg       <= SRC_DEBUG_WAIT;
      links_reg      <= 1'b0;
      bypass_reg     <= 1'b0;
    end else begin
      edge_cnt_reg   <= edge_cnt_next;
      strap_done_reg <= strap_done_next;
      pll_code_reg   <= pll_code_next;
      boot_mode_reg  <= boot_mode_next;
      pll_reg        <= pll_next;
      pre_reg        <= pre_next;
      timer_reg      <= timer_next;
      tile_khz_reg   <= tile_khz_next;
      range_err_reg  <= range_err_next;
      ld_reg         <= ld_next;
      row_reg        <= row_next;
      sec_reg        <= sec_next;
      go_reg         <= go_next;
      src0_reg       <= src0_next;
      src1_reg       <= src1_next;
      links_reg      <= links_next;
      bypass_reg     <= bypass_next;
    end
  end

  // Security gating; everything stays shut until the word is loaded
  assign sec_valid   = ld_reg != LD_STRAP && ld_reg != LD_SEC;
  assign secure      = sec_reg[SEC_SECURE];
  assign run         = ld_reg == LD_RUN;
  assign sector_lock = sec_reg[SEC_SECTOR_LO + sw_otp_addr[OTP_AW-1 -: SECTOR_W]];
  assign dbg_grant      = dbg_req && sec_valid && !sec_reg[SEC_DBG_DIS];
  assign link_acc_grant = link_acc_req && sec_valid && !sec_reg[SEC_LINK_DIS];
  assign sw_otp_grant   = sw_otp_req && run && !sec_reg[SEC_MASTER] && !sector_lock;
  assign sw_otp_refused = sw_otp_req && !sw_otp_grant;
  // Pin only ever pulled low; released when the feature is disabled
  assign debug_sync_out   = 1'b0;
  assign debug_sync_oe    = debug_break && sec_valid && !sec_reg[SEC_GDBG_DIS];
  assign debug_sync_event = !dsync_sync_reg && sec_valid && !sec_reg[SEC_GDBG_DIS];

  // OTP port shared; loader owns it until boot
  assign otp_rd_req  = ld_reg == LD_SEC || ld_reg == LD_COPY || sw_otp_grant;
  assign otp_rd_addr = (ld_reg == LD_SEC) ? OTP_BOOT_ADDR :
                       (ld_reg == LD_COPY) ? row_reg : sw_otp_addr;

  // SRAM port: copy writes win, processor waits for boot
  assign copy_wr   = ld_reg == LD_COPY && otp_rd_valid;
  assign mem.en    = copy_wr || (cpu_mem_en && run);
  assign mem.we    = copy_wr || cpu_mem_we;
  assign mem.size  = copy_wr ? SZ_WORD : cpu_mem_size;
  assign mem.addr  = copy_wr ? {14'(row_reg - OTP_AW'(1)), 2'h0} : cpu_mem_addr;
  assign mem.wdata = copy_wr ? otp_rd_data : cpu_mem_wdata;
  assign cpu_mem_rdata = mem.rdata;
  assign cpu_mem_ready = run;

  tbcc_sram #(.WORDS(SRAM_WORDS)) u_sram (
    .clk (clk),
    .bus (mem)
  );

  assign output_divider    = pll_reg.od;
  assign fb_mult           = pll_reg.fb;
  assign in_div            = pll_reg.r;
  assign tile_khz          = tile_khz_reg;
  assign vco_range_err     = range_err_reg;
  assign timer_value       = timer_reg;
  assign security_word     = sec_reg;
  assign first_tile_src    = src0_reg;
  assign second_tile_src   = src1_reg;
  assign link_b_en         = links_reg;
  assign internal_links_en = links_reg;
  assign boot_rom_bypass   = bypass_reg;
  assign boot_otp_addr     = OTP_BOOT_ADDR;
  assign boot_go           = go_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_timer_tick_step: assert property (tick |=> timer_value == $past(timer_value) + 32'h1)
    else $error("timer did not advance on tick");
  a_strap_third_edge: assert property ($fell(rst) ##1 !rst ##1 !rst
      |=> strap_done_reg && !$past(strap_done_reg))
    else $error("straps not taken on third edge");
  a_pll_strap_default: assert property ($rose(strap_done_reg)
      |-> pll_reg == tbcc_pll_default(pll_code_reg))
    else $error("wrong default clock setting");
  a_pll_sw_write: assert property (cfg_wr && strap_done_reg |=> output_divider ==
      $past(cfg_output_divider) && fb_mult == $past(cfg_fb_mult) && in_div == $past(cfg_in_div))
    else $error("clock write not applied");
  a_tile_freq_calc: assert property ($stable(pll_reg) && $stable(osc_khz) |=> tile_khz ==
      32'((48'($past(osc_khz)) * (48'($past(fb_mult)) + 48'h1))
      / (48'h2 * (48'($past(in_div)) + 48'h1))
      / (48'($past(output_divider)) + 48'h1)))
    else $error("tile rate mismatch");
  a_boot_debug_wait: assert property (boot_go && !secure && !boot_mode_reg[BOOT_SEL_BIT]
      |-> first_tile_src == SRC_DEBUG_WAIT && second_tile_src == SRC_DEBUG_WAIT)
    else $error("debug wait code not honoured");
  a_boot_link_code: assert property (boot_go && !secure && boot_mode_reg == BOOT_LINK
      |-> first_tile_src == SRC_LINK_B && second_tile_src == SRC_CHANEND0)
    else $error("link boot code wrong");
  a_boot_chan_code: assert property (boot_go && !secure && boot_mode_reg == BOOT_CHAN
      |-> link_b_en && internal_links_en && second_tile_src == SRC_CHANEND0)
    else $error("channel boot code wrong");
  a_otp_override: assert property (ld_reg == LD_BOOT && secure |=> boot_go &&
      first_tile_src == SRC_OTP && second_tile_src == SRC_OTP && boot_rom_bypass)
    else $error("secure boot not forced");
  a_sec_load_word: assert property (ld_reg == LD_SEC && otp_rd_valid
      |=> security_word == $past(otp_rd_data) && !boot_go)
    else $error("security word not loaded");
  a_copy_to_sram: assert property (copy_wr |-> mem.en && mem.we && mem.wdata == otp_rd_data
      ##1 ld_reg != LD_STRAP)
    else $error("row copy not written");
  a_scan_blocked: assert property (sec_reg[SEC_DBG_DIS] || !sec_valid |-> !dbg_grant)
    else $error("scan access leaked");
  a_link_blocked: assert property (sec_reg[SEC_LINK_DIS] |-> !link_acc_grant)
    else $error("remote access leaked");
  a_sync_pin_quiet: assert property (sec_reg[SEC_GDBG_DIS]
      |-> !debug_sync_oe && !debug_sync_event)
    else $error("sync pin used while disabled");
  a_otp_lock_refuse: assert property (sw_otp_req && (sec_reg[SEC_MASTER] || sector_lock)
      |-> sw_otp_refused && !sw_otp_grant)
    else $error("locked OTP access granted");

  c_secure_boot: cover property (boot_go && boot_rom_bypass);
  c_both_spi: cover property (boot_go && first_tile_src == SRC_SPI && second_tile_src == SRC_SPI);
  c_sw_clock_write: cover property (cfg_wr && strap_done_reg ##1 vco_range_err);
  c_otp_refused: cover property (sw_otp_refused && run);
endmodule

// File: pkg/tbcc_pkg.sv
package tbcc_pkg;
  localparam int TIMER_W     = 32;
  localparam int CLK_NS      = 10;
  localparam int TICK_NS     = 10;
  localparam int TICK_CYC    = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int STRAP_EDGE  = 3;
  localparam int OD_W        = 3;
  localparam int FB_W        = 12;
  localparam int IN_W        = 6;
  localparam int OSC_W       = 20;
  localparam int FB_HALF     = 2;
  localparam int VCO_MIN_KHZ = 260000;
  localparam int VCO_MAX_KHZ = 1300000;
  localparam int OTP_ROWS    = 2048;
  localparam int OTP_AW      = 11;
  localparam int SECTOR_W    = 2;
  localparam int SECTORS     = 4;
  localparam int SRAM_AW     = 16;
  localparam int SRAM_WORDS  = 16384;
  localparam logic [OTP_AW-1:0] OTP_BOOT_ADDR = 11'h000;
  // Security word layout
  localparam int SEC_DBG_DIS   = 0;
  localparam int SEC_LINK_DIS  = 1;
  localparam int SEC_GDBG_DIS  = 2;
  localparam int SEC_MASTER    = 3;
  localparam int SEC_SECURE    = 5;
  localparam int SEC_SECTOR_LO = 6;
  // Boot strap codes, bit BOOT_SEL_BIT low means debug wait
  localparam int BOOT_SEL_BIT = 1;
  localparam logic [2:0] BOOT_LINK = 3'h2;
  localparam logic [2:0] BOOT_SPI0 = 3'h3;
  localparam logic [2:0] BOOT_CHAN = 3'h6;
  typedef enum logic [2:0] {SRC_DEBUG_WAIT, SRC_LINK_B, SRC_CHANEND0,
                            SRC_SPI, SRC_OTP} tbcc_src_e;
  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} tbcc_size_e;
  typedef enum logic [2:0] {LD_STRAP, LD_SEC, LD_COPY, LD_BOOT, LD_RUN} tbcc_ld_e;
  typedef struct packed {
    logic [OD_W-1:0] od;
    logic [FB_W-1:0] fb;
    logic [IN_W-1:0] r;
  } tbcc_pll_s;
  localparam tbcc_pll_s PLL_DEF_00 = '{od: 3'h1, fb: 12'h07A, r: 6'h00};
  localparam tbcc_pll_s PLL_DEF_11 = '{od: 3'h2, fb: 12'h077, r: 6'h00};
  localparam tbcc_pll_s PLL_DEF_10 = '{od: 3'h2, fb: 12'h031, r: 6'h00};
  localparam tbcc_pll_s PLL_DEF_01 = '{od: 3'h2, fb: 12'h017, r: 6'h00};

  // Default clock setting per clock strap code
  function automatic tbcc_pll_s tbcc_pll_default(input logic [1:0] code);
    unique case (code)
      2'h0: return PLL_DEF_00;
      2'h3: return PLL_DEF_11;
      2'h2: return PLL_DEF_10;
      default: return PLL_DEF_01;
    endcase
  endfunction

  // Boot source of one tile from the boot strap code
  function automatic tbcc_src_e tbcc_boot_src(input logic [2:0] mode, input logic second);
    if (!mode[BOOT_SEL_BIT]) return SRC_DEBUG_WAIT;
    unique case (mode)
      BOOT_LINK: return second ? SRC_CHANEND0 : SRC_LINK_B;
      BOOT_SPI0: return second ? SRC_CHANEND0 : SRC_SPI;
      BOOT_CHAN: return SRC_CHANEND0;
      default:   return SRC_SPI;
    endcase
  endfunction
endpackage

// File: pkg/tbcc_mem_if.sv
`timescale 1ns/1ps
interface tbcc_mem_if;
  import tbcc_pkg::*;
  logic                en;
  logic                we;
  tbcc_size_e          size;
  logic [SRAM_AW-1:0]  addr;
  logic [31:0]         wdata;
  logic [31:0]         rdata;
  modport host (output en, we, size, addr, wdata, input rdata);
  modport mem  (input en, we, size, addr, wdata, output rdata);
endinterface

// File: src/tbcc_sram.sv
`timescale 1ns/1ps
module tbcc_sram #(
  parameter int WORDS = tbcc_pkg::SRAM_WORDS
) (
  input wire logic clk, // System clock
  tbcc_mem_if.mem  bus  // Access port
);
  import tbcc_pkg::*;
  logic [31:0] mem_reg [WORDS];
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [31:0] wide_data;
  logic [3:0]  lane_we;
  logic [SRAM_AW-3:0] widx;
  logic [4:0]  shift;

  // Lane enables and replicated data; narrow writes land on their own lanes
  always_comb begin
    widx = bus.addr[SRAM_AW-1:2];
    shift = {bus.addr[1:0], 3'h0};
    unique case (bus.size)
      SZ_BYTE: begin
        wide_data = {4{bus.wdata[7:0]}};
        lane_we = 4'h1 << bus.addr[1:0];
      end
      SZ_HALF: begin
        wide_data = {2{bus.wdata[15:0]}};
        lane_we = bus.addr[1] ? 4'hC : 4'h3;
      end
      default: begin
        wide_data = bus.wdata;
        lane_we = 4'hF;
      end
    endcase
    rdata_next = (bus.en && !bus.we) ? (mem_reg[widx] >> shift) : rdata_reg;
  end

  // Byte lanes written in the access cycle
  for (genvar g = 0; g < 4; g++) begin : g_lane
    always_ff @(posedge clk) begin
      if (bus.en && bus.we && lane_we[g]) begin
        mem_reg[widx][8*g +: 8] <= wide_data[8*g +: 8];
      end
    end
  end

  // Read data lands one cycle after the request, low aligned
  always_ff @(posedge clk) begin
    rdata_reg <= rdata_next;
  end
  assign bus.rdata = rdata_reg;

  default clocking cb @(posedge clk); endclocking

  a_sram_word_rw: assert property (bus.en && bus.we && bus.size == SZ_WORD ##1
      bus.en && !bus.we && bus.addr == $past(bus.addr)
      |=> bus.rdata == $past(bus.wdata, 2))
    else $error("word read back differs");
  a_sram_byte_rd: assert property (bus.en && !bus.we && bus.size == SZ_BYTE
      |=> bus.rdata[31:8] == $past(mem_reg[widx] >> (6'(shift) + 6'h08)))
    else $error("byte read not aligned low");
endmodule

// File: verification/tbcc_otp_model.sv
`timescale 1ns/1ps
// Row array of the fuse memory; answers in the cycle of the request
module tbcc_otp_model (
  input  wire logic [10:0] addr,  // Row address
  input  wire logic        req,   // Row request
  input  wire logic [31:0] sec,   // Row 0 content
  output logic [31:0]      data,  // Row data
  output logic             valid  // Data valid
);
  logic [31:0] row;
  assign row = (addr == 11'h000) ? sec : {21'h0, addr};
  // Idle bus shows inverted data so a stale value is never trusted
  assign data  = req ? row : ~row;
  assign valid = req;
endmodule

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import tbcc_pkg::*;
  logic clk, rst, cfg_wr, orq, ovl, sreq, dreq, lreq, brk, go;
  logic [1:0] ps;
  logic [2:0] bs, od, cod;
  logic [11:0] fb, cfb;
  logic [5:0] ind, cin;
  logic [10:0] oad;
  logic [31:0] sec, od_data, tk, tv, t0;
  logic sgr, srf, dgr, lgr, soe, vco, byp, lbe, dsn, dse;
  logic [19:0] osc;
  logic [10:0] soa;
  tbcc_src_e s0, s1;
  int n_mismatch = 0, compares = 0, k;
  tbcc_top #(.COPY_ROWS(2)) dut (.clk(clk), .rst(rst), .pll_strap(ps), .boot_strap(bs),
    .osc_khz(osc), .cfg_wr(cfg_wr), .cfg_output_divider(cod), .cfg_fb_mult(cfb),
    .cfg_in_div(cin), .output_divider(od), .fb_mult(fb), .in_div(ind), .tile_khz(tk),
    .vco_range_err(vco), .timer_value(tv), .otp_rd_req(orq), .otp_rd_addr(oad),
    .otp_rd_data(od_data), .otp_rd_valid(ovl), .sw_otp_req(sreq), .sw_otp_addr(soa),
    .sw_otp_grant(sgr), .sw_otp_refused(srf), .security_word(), .first_tile_src(s0),
    .second_tile_src(s1), .link_b_en(lbe), .internal_links_en(), .boot_rom_bypass(byp),
    .boot_otp_addr(), .boot_go(go), .cpu_mem_en(1'b0), .cpu_mem_we(1'b0),
    .cpu_mem_size(SZ_WORD), .cpu_mem_addr(16'h0000), .cpu_mem_wdata(32'h0),
    .cpu_mem_rdata(), .cpu_mem_ready(), .dbg_req(dreq), .dbg_grant(dgr),
    .link_acc_req(lreq), .link_acc_grant(lgr), .debug_sync_in_n(dsn),
    .debug_sync_out(), .debug_sync_oe(soe), .debug_break(brk), .debug_sync_event(dse));
  tbcc_otp_model otp (.addr(oad), .req(orq), .sec(sec), .data(od_data), .valid(ovl));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Inputs move 1 ns after the edge so no race with the sampling edge
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Reset with new straps and fuse word, then wait a bounded time for boot
  task automatic boot(input logic [1:0] p, input logic [2:0] b, input logic [31:0] s);
    int i;
    ps = p; bs = b; sec = s; rst = 1;
    repeat (12) tick();
    rst = 0;
    for (i = 0; i < 100 && go !== 1'b1; i++) tick();
    if (i == 100) chk(0, 1);
  endtask
  // Clock setting write, checked at the documented one- and two-cycle marks
  task automatic cfg(input logic [2:0] o, input logic [11:0] f, input logic [5:0] r,
                     input logic [31:0] t, input logic e);
    cfg_wr = 1; cod = o; cfb = f; cin = r;
    tick();
    cfg_wr = 0;
    chk({od, fb, ind}, {o, f, r});
    tick();
    chk(tk, t);
    chk(vco, e);
  endtask
  logic [2:0] bt [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7, 3'h7};
  tbcc_src_e x0 [7] = '{SRC_DEBUG_WAIT, SRC_DEBUG_WAIT, SRC_LINK_B, SRC_SPI, SRC_CHANEND0,
                        SRC_SPI, SRC_OTP};
  tbcc_src_e x1 [7] = '{SRC_DEBUG_WAIT, SRC_DEBUG_WAIT, SRC_CHANEND0, SRC_CHANEND0,
                        SRC_CHANEND0, SRC_SPI, SRC_OTP};
  int fx [4] = '{122, 23, 49, 119};
  initial begin
    rst = 1; cfg_wr = 0; cod = 0; cfb = 0; cin = 0; ps = 0; bs = 0; sec = 0;
    sreq = 1; dreq = 1; lreq = 1; brk = 1; dsn = 1; osc = 20'd20000; soa = 11'h000;
    for (k = 0; k < 7; k++) begin
      boot(k[1:0], bt[k], (k == 6) ? 32'h21 : 32'h0);
      chk(fb, fx[k % 4]);
      chk({od, ind}, {(k % 4 == 0) ? 3'h1 : 3'h2, 6'h0});
      chk(s0, x0[k]);
      chk(s1, x1[k]);
      chk(lbe, k == 4);
      chk(byp, k == 6);
      chk(dgr, k != 6);
      chk(sgr, 1);
      chk(soe, 1);
      $display("test boot %0d done", k);
    end
    // Sync pin pulled low: seen while allowed, ignored once disabled
    dsn = 0;
    repeat (2) tick();
    chk(dse, 1);
    boot(2'h0, 3'h0, 32'h0E);
    chk(lgr, 0);
    chk(soe, 0);
    chk(dse, 0);
    dsn = 1;
    chk(srf, 1);
    boot(2'h0, 3'h0, 32'h40);
    chk(srf, 1);
    soa = 11'h200;
    tick();
    chk(sgr, 1);
    soa = 11'h000;
    $display("test locks done");
    t0 = tv;
    tick();
    chk(tv, t0 + 1);
    cfg(3'h1, 12'd99, 6'h1, 32'd250000, 0);
    cfg(3'h0, 12'd9, 6'h0, 32'd100000, 1);
    osc = 20'd40000;
    repeat (2) tick();
    chk(tk, 32'd200000);
    $display("test clock done");
    stop_test();
  end
  // Whole run is a few hundred cycles; a far larger span means a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
endmodule
